// ---- src/host_port_defines.svh ----
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// Host address pin span: word address bits 2 up to ADDR_MSB
`define ADDR_LSB 2
`define ADDR_MSB_DEFAULT 15
// Level that selects little endian, 32 bit and multiplexed bus
`define STRAP_LITTLE_LVL 1'b1
`define STRAP_WIDE_LVL 1'b1
`define STRAP_MUX_LVL 1'b1
// Reset values of the latched strap configuration
`define CFG_LITTLE_RST 1'b0
`define CFG_WIDE_RST 1'b0
`define CFG_MUX_RST 1'b0
// Chip select idle level
`define CS_IDLE_LVL 1'b1

`endif

// ---- src/host_port_pkg.sv ----
package host_port_pkg;
    // Bus configuration latched from the straps
    typedef struct packed {
        logic little_endian;
        logic wide_bus;
        logic multiplexed;
    } bus_cfg_s;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } access_state_e;
endpackage

// ---- src/strap_latch.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

// Samples the straps on the first clock after reset release
module strap_latch (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic byte_order_strap,
    input wire logic bus_width_strap,
    input wire logic bus_multiplex_strap,
    output var host_port_pkg::bus_cfg_s cfg,
    output logic cfg_valid
);
    logic taken_r;
    host_port_pkg::bus_cfg_s cfg_r;
    host_port_pkg::bus_cfg_s cfg_nxt;

    // Decode strap levels to configuration
    assign cfg_nxt.little_endian = (byte_order_strap == `STRAP_LITTLE_LVL);
    assign cfg_nxt.wide_bus = (bus_width_strap == `STRAP_WIDE_LVL);
    assign cfg_nxt.multiplexed = (bus_multiplex_strap == `STRAP_MUX_LVL);

    // Straps stay open while reset is low; caught once on the first clock after release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            taken_r <= 1'b0;
            cfg_r <= '{`CFG_LITTLE_RST, `CFG_WIDE_RST, `CFG_MUX_RST};
        end else if (!taken_r) begin
            taken_r <= 1'b1;
            cfg_r <= cfg_nxt;
        end
    end

    assign cfg = cfg_r;
    assign cfg_valid = taken_r;
endmodule // strap_latch
`default_nettype wire

// ---- src/host_bus_strap_config.sv ----
// Operation
// - Capture address at chip select falling edge.
// - Chip select rising edge ends access.
// - Reset low initialises every internal register.
// - Straps open for sampling during reset.
// - Byte order strap latched; high little-endian.
// - Width strap latched; high 32, low 16.
// - Multiplex strap latched; high multiplexed bus.
// - Nonmux address sampled at CS fall, word-aligned.
// - Multiplexed: address bit2 pin becomes latch enable.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

module host_bus_strap_config #(
    parameter int ADDR_MSB = `ADDR_MSB_DEFAULT,
    parameter int DATA_W = 32
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic byte_order_strap,
    input wire logic bus_width_strap,
    input wire logic bus_multiplex_strap,
    input wire logic cs_n,
    input wire logic addr_bit2_or_latch_enable,
    input wire logic [ADDR_MSB:`ADDR_LSB+1] addr_hi,
    input wire logic [DATA_W-1:0] mux_ad,
    output logic little_endian,
    output logic wide_bus,
    output logic multiplexed,
    output logic cfg_valid,
    output logic access_start,
    output logic access_end,
    output logic access_active,
    output logic [ADDR_MSB:`ADDR_LSB] access_addr
);
    // Elaboration check: address pins must fit inside the multiplexed bus
    if (ADDR_MSB <= `ADDR_LSB || ADDR_MSB >= DATA_W || DATA_W != 32) begin : g_bad_param
        $error("host_bus_strap_config: unsupported ADDR_MSB or DATA_W");
    end

    host_port_pkg::bus_cfg_s cfg;
    host_port_pkg::access_state_e state_r;
    host_port_pkg::access_state_e state_nxt;
    logic cs_prev_r;
    logic [ADDR_MSB:`ADDR_LSB] ale_addr_r;
    logic [ADDR_MSB:`ADDR_LSB] addr_r;
    logic start_r;
    logic end_r;
    logic cs_fall;
    logic cs_rise;
    logic take;
    logic ale_on;
    logic [ADDR_MSB:`ADDR_LSB] pin_addr;
    logic [ADDR_MSB:`ADDR_LSB] sel_addr;

    strap_latch u_strap (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .byte_order_strap(byte_order_strap),
        .bus_width_strap(bus_width_strap),
        .bus_multiplex_strap(bus_multiplex_strap),
        .cfg(cfg),
        .cfg_valid(cfg_valid)
    );

    // Chip select edges frame each access; ignored until straps are held
    assign cs_fall = cfg_valid && cs_prev_r && !cs_n;
    assign cs_rise = !cs_prev_r && cs_n;
    // A fall is taken outside an access, also in the cycle that leaves the strap state
    assign take = cs_fall && (state_r != host_port_pkg::ST_ACCESS);
    // Pin 2 is an address bit or the latch enable depending on the bus mode
    assign ale_on = cfg.multiplexed && addr_bit2_or_latch_enable;
    assign pin_addr = {addr_hi, addr_bit2_or_latch_enable};
    assign sel_addr = cfg.multiplexed ? ale_addr_r : pin_addr;

    // Access state walk; a new fall needs chip select back high first
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            host_port_pkg::ST_STRAP: begin
                if (take) begin
                    state_nxt = host_port_pkg::ST_ACCESS;
                end else if (cfg_valid) begin
                    state_nxt = host_port_pkg::ST_IDLE;
                end
            end
            host_port_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    state_nxt = host_port_pkg::ST_ACCESS;
                end
            end
            host_port_pkg::ST_ACCESS: begin
                if (cs_rise) begin
                    state_nxt = host_port_pkg::ST_IDLE;
                end
            end
            default: state_nxt = host_port_pkg::ST_STRAP;
        endcase
    end

    // Every register forced to its initial value while reset is low
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= host_port_pkg::ST_STRAP;
            cs_prev_r <= `CS_IDLE_LVL;
            ale_addr_r <= '0;
            addr_r <= '0;
            start_r <= 1'b0;
            end_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cs_prev_r <= cs_n;
            start_r <= take;
            end_r <= (state_r == host_port_pkg::ST_ACCESS) && cs_rise;
            if (ale_on) begin
                ale_addr_r <= mux_ad[ADDR_MSB:`ADDR_LSB];
            end
            if (take) begin
                addr_r <= sel_addr;
            end
        end
    end

    assign little_endian = cfg.little_endian;
    assign wide_bus = cfg.wide_bus;
    assign multiplexed = cfg.multiplexed;
    assign access_start = start_r;
    assign access_end = end_r;
    assign access_active = (state_r == host_port_pkg::ST_ACCESS);
    assign access_addr = addr_r;
endmodule // host_bus_strap_config
`default_nettype wire

// ---- dv/host_bus_strap_config_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
// Port checks of strap latching and chip select framing
module host_bus_strap_config_asserts #(parameter int ADDR_MSB = 15) (
    input wire logic sys_clk, resetn, byte_order_strap, bus_width_strap,
    input wire logic bus_multiplex_strap, cs_n, addr_bit2_or_latch_enable,
    input wire logic [ADDR_MSB:3] addr_hi,
    input wire logic little_endian, wide_bus, multiplexed, cfg_valid,
    input wire logic access_start, access_end, access_active,
    input wire logic [ADDR_MSB:2] access_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    AST_ADDR: assert property ($fell(cs_n) && cfg_valid && !access_active
        && !multiplexed |=> access_start
        && access_addr == $past({addr_hi, addr_bit2_or_latch_enable})) else $error("bad addr");
    AST_END: assert property ($rose(cs_n) && access_active |=> access_end
        && !access_active) else $error("no end");
    AST_ONE: assert property (access_start |-> access_active ##1 !access_start)
        else $error("long start");
    AST_RST: assert property (disable iff (1'b0) !resetn |-> !cfg_valid && !access_active)
        else $error("not reset");
    AST_ORD: assert property ($rose(cfg_valid) |-> little_endian == $past(byte_order_strap))
        else $error("bad order");
    AST_WID: assert property ($rose(cfg_valid) |-> wide_bus == $past(bus_width_strap))
        else $error("bad width");
    AST_MUX: assert property ($rose(cfg_valid) |-> multiplexed == $past(bus_multiplex_strap))
        else $error("bad mux");
    AST_HOLD: assert property (cfg_valid |=> cfg_valid
        && $stable({little_endian, wide_bus, multiplexed})) else $error("cfg moved");
endmodule // host_bus_strap_config_asserts
bind host_bus_strap_config host_bus_strap_config_asserts #(.ADDR_MSB(ADDR_MSB)) chk_inst (
    .sys_clk, .resetn, .byte_order_strap, .bus_width_strap, .bus_multiplex_strap, .cs_n,
    .addr_bit2_or_latch_enable, .addr_hi, .little_endian, .wide_bus, .multiplexed,
    .cfg_valid, .access_start, .access_end, .access_active, .access_addr);
`default_nettype wire

// ---- dv/host_bus_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host bus controller; address lines scramble once the capture edge has passed
module host_bus_partner (
    input wire logic sys_clk,
    output var logic cs_n = 1'b1,
    output var logic lat_en = 1'b0,
    output var logic [15:3] hi = 13'h0,
    output var logic [31:0] ad = 32'h0
);
    task automatic xfer(input logic [15:2] a, input logic mx, input int n);
        @(negedge sys_clk);
        if (mx) begin
            lat_en <= 1'b1;
            ad <= {16'h0, a, 2'h0};
            @(negedge sys_clk);
            lat_en <= 1'b0;
            ad <= ~ad;
        end else
            {hi, lat_en} <= a;
        cs_n <= 1'b0;
        @(negedge sys_clk);
        if (!mx) {hi, lat_en} <= ~a;
        repeat (n) @(negedge sys_clk);
        cs_n <= 1'b1;
    endtask
endmodule // host_bus_partner
`default_nettype wire

// ---- dv/host_bus_strap_config_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_bus_strap_config_tb_top;
    logic sys_clk = 1'b0;
    logic resetn = 1'b1;
    logic [2:0] strap = 3'h0;
    logic [15:2] a;
    logic cs_n, lat_en, little_endian, wide_bus, multiplexed, cfg_valid;
    logic access_start, access_end, access_active;
    logic [15:3] hi;
    logic [31:0] ad;
    logic [15:2] access_addr;
    logic [15:2] exp_q[$];
    int seed = 87855;
    int miscompares = 0;
    int n_compared = 0;
    int ends = 0;
    host_bus_partner host_bus_partner_inst (.sys_clk, .cs_n, .lat_en, .hi, .ad);
    host_bus_strap_config host_bus_strap_config_inst (.sys_clk, .resetn,
        .byte_order_strap(strap[2]), .bus_width_strap(strap[1]), .bus_multiplex_strap(strap[0]),
        .cs_n, .addr_bit2_or_latch_enable(lat_en), .addr_hi(hi), .mux_ad(ad), .little_endian,
        .wide_bus, .multiplexed, .cfg_valid, .access_start, .access_end, .access_active,
        .access_addr);
    initial forever #4 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Model: every start pops the address the host issued, every end is counted
    always @(negedge sys_clk) begin
        if (access_start === 1'b1) chk({2'h0, access_addr}, {2'h0, exp_q.pop_front()});
        if (access_end === 1'b1) ends++;
    end
    // All strap combinations, each behind its own reset; accesses back to back
    initial begin
        for (int s = 0; s < 8; s++) begin
            resetn <= 1'b0;
            strap <= s[2:0];
            repeat (6) @(negedge sys_clk);
            chk(16'({cfg_valid, access_active, access_start}), 16'h0);
            resetn <= 1'b1;
            repeat (2) @(negedge sys_clk);
            chk(16'({little_endian, wide_bus, multiplexed}), 16'(strap));
            ends = 0;
            for (int i = 0; i < 5; i++) begin
                a = 14'($random(seed));
                exp_q.push_back(a);
                host_bus_partner_inst.xfer(a, strap[0], $random(seed) & 3);
            end
            repeat (3) @(negedge sys_clk);
            chk(16'(ends), 16'h5);
        end
        report_and_stop();
    end
    // Whole run needs about 2 us
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule // host_bus_strap_config_tb_top
`default_nettype wire
